//--- src/ecl_ee_rd.sv
// serial eeprom single word reader
`timescale 1ns/1ps
`default_nettype none
module ecl_ee_rd
  import ecl_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic start_in, // start a word read
  input wire logic [7:0] addr_in, // eeprom word address
  output logic busy_out, // read in progress
  output logic done_out, // one-cycle pulse, data valid
  output logic [15:0] data_out, // word read
  output logic ee_cs_out, // chip select
  output logic ee_sk_out, // serial clock
  output logic ee_di_out, // serial data to eeprom
  input wire logic ee_do_in // serial data from eeprom
);
  logic do_s1_q, do_s2_q;
  logic busy_q, busy_d, done_q, done_d, cs_q, cs_d, sk_q, sk_d, di_q, di_d;
  logic [7:0] ph_q, ph_d;
  logic [4:0] bit_q, bit_d;
  logic [10:0] sr_q, sr_d;
  logic [15:0] data_q, data_d;

  // shift sequence; one word spans EE_BITS serial clocks, about the word time
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    cs_d = cs_q;
    sk_d = sk_q;
    di_d = di_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sr_d = sr_q;
    data_d = data_q;
    if (!busy_q) begin
      if (start_in) begin
        busy_d = 1'b1;
        cs_d = 1'b1;
        ph_d = 8'h00;
        bit_d = 5'h00;
        sr_d = {EE_CMD_READ, addr_in};
      end
    end else begin
      ph_d = ph_q + 8'h01;
      if (ph_q == 8'h00) begin
        sk_d = 1'b0;
        di_d = (bit_q < 5'(CMD_BITS)) ? sr_q[10] : 1'b0;
        sr_d = {sr_q[9:0], 1'b0};
      end
      if (ph_q == 8'(SK_HALF)) begin
        sk_d = 1'b1;
      end
      // sample just before the rising edge, long after the part drove it
      if (ph_q == 8'(SK_HALF - 1) && bit_q >= 5'(CMD_BITS + 1)) begin
        data_d = {data_q[14:0], do_s2_q};
      end
      if (ph_q == 8'(2 * SK_HALF - 1)) begin
        ph_d = 8'h00;
        if (bit_q == 5'(EE_BITS - 1)) begin
          busy_d = 1'b0;
          done_d = 1'b1;
          cs_d = 1'b0;
          sk_d = 1'b0;
          di_d = 1'b0;
        end else begin
          bit_d = bit_q + 5'h01;
        end
      end
    end
  end

  // register stage, including the two-flop input synchroniser
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      do_s1_q <= 1'b0;
      do_s2_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      di_q <= 1'b0;
      ph_q <= 8'h00;
      bit_q <= 5'h00;
      sr_q <= 11'h000;
      data_q <= 16'h0000;
    end else begin
      do_s1_q <= ee_do_in;
      do_s2_q <= do_s1_q;
      busy_q <= busy_d;
      done_q <= done_d;
      cs_q <= cs_d;
      sk_q <= sk_d;
      di_q <= di_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sr_q <= sr_d;
      data_q <= data_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign data_out = data_q;
  assign ee_cs_out = cs_q;
  assign ee_sk_out = sk_q;
  assign ee_di_out = di_q;
endmodule : ecl_ee_rd
`default_nettype wire

//--- src/ecl_loader.sv
// reset configuration loader with avalon register access
// Contract
// - probe for eeprom after every reset
// - copy first block into internal registers
// - each word fetch takes about 25 us
// - first word gives type and byte count
// - last word high byte is 8-bit checksum
// - group header: count-1 nibble, 12-bit address
// - software may read any eeprom word
// - io base defaults to 300h
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int unsigned IREG_N = 64
)
(
  input wire logic clk_in, // system clock, 25 MHz
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [6:0] avs_address_in, // word index
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall, high until answered
  output logic [15:0] io_base_out, // loaded io base word
  output logic load_done_out, // reset load finished
  output logic ee_cs_out, // eeprom chip select
  output logic ee_sk_out, // eeprom serial clock
  output logic ee_di_out, // eeprom data in
  input wire logic ee_do_in // eeprom data out, asynchronous
);
  import ecl_pkg::*;
  localparam int unsigned IW = $clog2(IREG_N);

  ecl_state_t st_q, st_d;
  logic rd_start, rd_busy, rd_done;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic [7:0] ptr_q, ptr_d, sum_q, sum_d, eeaddr_q, eeaddr_d;
  logic [6:0] left_q, left_d;
  logic [4:0] grp_cnt_q, grp_cnt_d;
  logic [11:0] grp_addr_q, grp_addr_d;
  logic [15:0] eedata_q, eedata_d;
  logic present_q, present_d, loaded_q, loaded_d, ckerr_q, ckerr_d, swdone_q, swdone_d;
  logic swgo_q, swgo_d, reload_q, reload_d, wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] ireg_q [IREG_N];
  logic [15:0] ireg_d [IREG_N];
  logic wr_acc, rd_acc;

  // ******************************
  // eeprom word reader
  // ******************************
  ecl_ee_rd u_rd (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(rd_start),
    .addr_in(rd_addr),
    .busy_out(rd_busy),
    .done_out(rd_done),
    .data_out(rd_data),
    .ee_cs_out(ee_cs_out),
    .ee_sk_out(ee_sk_out),
    .ee_di_out(ee_di_out),
    .ee_do_in(ee_do_in)
  );

  function automatic logic [15:0] ireg_rst(input int unsigned idx);
    return (idx == int'(IO_BASE_IDX)) ? IO_BASE_RST : 16'h0000;
  endfunction : ireg_rst

  // ******************************
  // avalon slave
  // ******************************
  // one wait cycle, then the answer stands for one cycle
  assign rd_acc = avs_read_in && !wait_q;
  assign wr_acc = avs_write_in && !wait_q;

  always_comb begin
    wait_d = !((avs_read_in || avs_write_in) && wait_q);
    rdata_d = rdata_q;
    if ((avs_read_in || avs_write_in) && wait_q) begin
      rdata_d = 32'h0000_0000;
      if (avs_address_in == REG_STAT) begin
        rdata_d[STAT_BUSY] = (st_q != ECL_IDLE);
        rdata_d[STAT_PRESENT] = present_q;
        rdata_d[STAT_LOADED] = loaded_q;
        rdata_d[STAT_CKERR] = ckerr_q;
        rdata_d[STAT_RDDONE] = swdone_q;
      end else if (avs_address_in == REG_EEADDR) begin
        rdata_d[7:0] = eeaddr_q;
      end else if (avs_address_in == REG_EEDATA) begin
        rdata_d[15:0] = eedata_q;
      end else if (avs_address_in >= REG_WIN && int'(avs_address_in - REG_WIN) < IREG_N) begin
        rdata_d[15:0] = ireg_q[IW'(avs_address_in - REG_WIN)];
      end
    end
  end

  // ******************************
  // load sequence
  // ******************************
  always_comb begin
    st_d = st_q;
    rd_start = 1'b0;
    rd_addr = ptr_q;
    ptr_d = ptr_q;
    sum_d = sum_q;
    left_d = left_q;
    grp_cnt_d = grp_cnt_q;
    grp_addr_d = grp_addr_q;
    eedata_d = eedata_q;
    eeaddr_d = eeaddr_q;
    present_d = present_q;
    loaded_d = loaded_q;
    ckerr_d = ckerr_q;
    swdone_d = swdone_q;
    swgo_d = swgo_q;
    reload_d = reload_q;
    ireg_d = ireg_q;
    // software writes first so that a loader store in the same cycle wins
    if (wr_acc && avs_address_in == REG_CTRL && avs_byteenable_in[0]) begin
      swgo_d = swgo_q | avs_writedata_in[CTRL_RD];
      reload_d = reload_q | avs_writedata_in[CTRL_RELOAD];
      if (avs_writedata_in[CTRL_RD]) begin
        swdone_d = 1'b0;
      end
    end
    if (wr_acc && avs_address_in == REG_EEADDR && avs_byteenable_in[0]) begin
      eeaddr_d = avs_writedata_in[7:0];
    end
    if (wr_acc && avs_address_in >= REG_WIN && int'(avs_address_in - REG_WIN) < IREG_N
        && avs_byteenable_in[1:0] == 2'h3) begin
      ireg_d[IW'(avs_address_in - REG_WIN)] = avs_writedata_in[15:0];
    end
    unique case (st_q)
      ECL_BOOT: begin
        rd_start = 1'b1;
        rd_addr = EE_BLOCK_ADDR;
        ptr_d = EE_BLOCK_ADDR + 8'h01;
        present_d = 1'b0;
        loaded_d = 1'b0;
        ckerr_d = 1'b0;
        st_d = ECL_W0;
      end
      ECL_W0: begin
        if (rd_done) begin
          if (rd_data[15:12] == EE_TYPE_NIB) begin
            present_d = 1'b1;
            left_d = rd_data[7:1];
            sum_d = rd_data[15:8] + rd_data[7:0];
            rd_start = 1'b1;
            ptr_d = ptr_q + 8'h01;
            // the byte count includes the checksum word, so one word left means checksum next
            st_d = (rd_data[7:1] <= 7'h01) ? ECL_CHK : ECL_GRP;
          end else begin
            loaded_d = 1'b1;
            st_d = ECL_IDLE;
          end
        end
      end
      ECL_GRP: begin
        if (rd_done) begin
          grp_cnt_d = {1'b0, rd_data[15:12]} + 5'h01;
          grp_addr_d = rd_data[11:0];
          sum_d = sum_q + rd_data[15:8] + rd_data[7:0];
          left_d = left_q - 7'h01;
          rd_start = 1'b1;
          ptr_d = ptr_q + 8'h01;
          st_d = (left_q == 7'h02) ? ECL_CHK : ECL_DAT;
        end
      end
      ECL_DAT: begin
        if (rd_done) begin
          if (grp_addr_q < 12'(IREG_N)) begin
            ireg_d[IW'(grp_addr_q)] = rd_data;
          end
          grp_addr_d = grp_addr_q + 12'h001;
          grp_cnt_d = grp_cnt_q - 5'h01;
          sum_d = sum_q + rd_data[15:8] + rd_data[7:0];
          left_d = left_q - 7'h01;
          rd_start = 1'b1;
          ptr_d = ptr_q + 8'h01;
          if (left_q == 7'h02) begin
            st_d = ECL_CHK;
          end else if (grp_cnt_q == 5'h01) begin
            st_d = ECL_GRP;
          end else begin
            st_d = ECL_DAT;
          end
        end
      end
      ECL_CHK: begin
        if (rd_done) begin
          sum_d = sum_q + rd_data[15:8];
          ckerr_d = ((sum_q + rd_data[15:8]) != 8'h00);
          loaded_d = 1'b1;
          st_d = ECL_IDLE;
        end
      end
      ECL_IDLE: begin
        if (reload_q) begin
          reload_d = 1'b0;
          st_d = ECL_BOOT;
        end else if (swgo_q) begin
          swgo_d = 1'b0;
          rd_start = 1'b1;
          rd_addr = eeaddr_q;
          st_d = ECL_SW;
        end
      end
      ECL_SW: begin
        if (rd_done) begin
          eedata_d = rd_data;
          swdone_d = 1'b1;
          st_d = ECL_IDLE;
        end
      end
    endcase
    if (!rst_n_in) begin
      for (int unsigned i = 0; i < IREG_N; i++) begin
        ireg_d[i] = ireg_rst(i);
      end
    end
  end

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge clk_in) begin
    ireg_q <= ireg_d;
    if (!rst_n_in) begin
      st_q <= ECL_BOOT;
      ptr_q <= 8'h00;
      sum_q <= 8'h00;
      left_q <= 7'h00;
      grp_cnt_q <= 5'h00;
      grp_addr_q <= 12'h000;
      eedata_q <= 16'h0000;
      eeaddr_q <= EE_DRV_ADDR;
      present_q <= 1'b0;
      loaded_q <= 1'b0;
      ckerr_q <= 1'b0;
      swdone_q <= 1'b0;
      swgo_q <= 1'b0;
      reload_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      io_base_out <= IO_BASE_RST;
      load_done_out <= 1'b0;
    end else begin
      st_q <= st_d;
      ptr_q <= ptr_d;
      sum_q <= sum_d;
      left_q <= left_d;
      grp_cnt_q <= grp_cnt_d;
      grp_addr_q <= grp_addr_d;
      eedata_q <= eedata_d;
      eeaddr_q <= eeaddr_d;
      present_q <= present_d;
      loaded_q <= loaded_d;
      ckerr_q <= ckerr_d;
      swdone_q <= swdone_d;
      swgo_q <= swgo_d;
      reload_q <= reload_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      io_base_out <= ireg_d[IW'(IO_BASE_IDX)];
      load_done_out <= loaded_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;

  // ******************************
  // checks
  // ******************************
  localparam int WMIN = 600;
  localparam int WMAX = 650;
  logic [9:0] bcnt_q;
  // busy length; still holds the full count at the edge that first sees busy low
  always_ff @(posedge clk_in) begin
    bcnt_q <= (!rst_n_in || !rd_busy) ? 10'h000 : bcnt_q + 10'h001;
  end

  property p_probe;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(rst_n_in) |-> st_q == ECL_BOOT ##1 rd_busy;
  endproperty
  a_probe: assert property (p_probe) else $error("no probe after reset");
  property p_store;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_DAT && rd_done && grp_addr_q == IO_BASE_IDX) |=> ##1 io_base_out == $past(rd_data, 2);
  endproperty
  a_store: assert property (p_store) else $error("block word not stored");
  property p_word_time;
    @(posedge clk_in) disable iff (!rst_n_in) $fell(rd_busy) |-> bcnt_q >= 10'(WMIN) && bcnt_q <= 10'(WMAX);
  endproperty
  a_word_time: assert property (p_word_time) else $error("word fetch time out of range");
  property p_header;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_W0 && rd_done && rd_data[15:12] == EE_TYPE_NIB) |=> present_q && left_q == $past(rd_data[7:1]);
  endproperty
  a_header: assert property (p_header) else $error("header not decoded");
  property p_cksum;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_CHK && rd_done) |=> ckerr_q == (sum_q != 8'h00) && loaded_q && st_q == ECL_IDLE;
  endproperty
  a_cksum: assert property (p_cksum) else $error("checksum flag wrong");
  property p_group;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_GRP && rd_done) |=> grp_cnt_q == 5'($past(rd_data[15:12])) + 5'h01
      && grp_addr_q == $past(rd_data[11:0]);
  endproperty
  a_group: assert property (p_group) else $error("group header not decoded");
  property p_swread;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_SW && rd_done) |=> eedata_q == $past(rd_data) && swdone_q ##1 !rd_busy;
  endproperty
  a_swread: assert property (p_swread) else $error("software read lost");
  property p_iobase;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(rst_n_in) |-> io_base_out == IO_BASE_RST;
  endproperty
  a_iobase: assert property (p_iobase) else $error("io base reset value wrong");
  property p_absent;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == ECL_W0 && rd_done && rd_data[15:12] != EE_TYPE_NIB) |=> st_q == ECL_IDLE && !present_q
      && io_base_out == $past(io_base_out);
  endproperty
  a_absent: assert property (p_absent) else $error("load not skipped");
endmodule : ecl_loader
`default_nettype wire

//--- src/ecl_pkg.sv
// constants for the reset configuration loader
package ecl_pkg;
  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned WORD_US = 25;
  localparam int unsigned WORD_CYC = (WORD_US * 1000) / CLK_NS;
  localparam int unsigned EE_BITS = 28;
  localparam int unsigned SK_HALF = WORD_CYC / (2 * EE_BITS);
  localparam int unsigned CMD_BITS = 11;
  localparam logic [2:0] EE_CMD_READ = 3'h6;
  // ******************************
  // block layout
  // ******************************
  localparam logic [3:0] EE_TYPE_NIB = 4'ha;
  localparam logic [7:0] EE_BLOCK_ADDR = 8'h00;
  localparam logic [7:0] EE_DRV_ADDR = 8'h1c;
  localparam logic [11:0] IO_BASE_IDX = 12'h020;
  localparam logic [15:0] IO_BASE_RST = 16'h0300;
  // ******************************
  // register map, word index
  // ******************************
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_STAT = 7'h01;
  localparam logic [6:0] REG_EEADDR = 7'h02;
  localparam logic [6:0] REG_EEDATA = 7'h03;
  localparam logic [6:0] REG_WIN = 7'h40;
  localparam int unsigned CTRL_RD = 0;
  localparam int unsigned CTRL_RELOAD = 1;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_PRESENT = 1;
  localparam int unsigned STAT_LOADED = 2;
  localparam int unsigned STAT_CKERR = 3;
  localparam int unsigned STAT_RDDONE = 4;
  typedef enum logic [2:0] {ECL_BOOT, ECL_W0, ECL_GRP, ECL_DAT, ECL_CHK, ECL_IDLE, ECL_SW} ecl_state_t;
endpackage : ecl_pkg

//--- tb/ecl_ee_model.sv
// behavioural three-wire serial configuration eeprom for the loader bench
`timescale 1ns/1ps
`default_nettype none
module ecl_ee_model (
  input wire logic present_in, // part fitted on the board
  input wire logic cs_in, // chip select
  input wire logic sk_in, // serial clock
  input wire logic di_in, // serial data into the part
  output logic do_out // serial data out, pulled up when released
);
  logic [15:0] mem [256];
  logic [10:0] cmd_q;
  logic do_q;
  int n_q;
  // blank part reads all ones, like an erased array
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hffff;
    end
  end
  // pull-up wins when the part is absent, deselected or not asked to read
  assign do_out = (present_in && cs_in && cmd_q[10:8] == 3'h6) ? do_q : 1'b1;
  // new frame restarts the bit count
  always @(posedge cs_in) begin
    n_q = 0;
    cmd_q = 11'h000;
  end
  // each bit is launched right after the sk rise it follows, giving the host a full period
  always @(posedge sk_in) begin
    if (cs_in) begin
      n_q = n_q + 1;
      if (n_q <= 11) begin
        cmd_q = {cmd_q[9:0], di_in};
      end
      if (n_q == 11) begin
        do_q <= 1'b0; // dummy zero ahead of the data
      end else if (n_q >= 12 && n_q <= 27) begin
        do_q <= mem[cmd_q[7:0]][27 - n_q];
      end else begin
        do_q <= ~do_q; // hold time over, line no longer meaningful
      end
    end
  end
endmodule : ecl_ee_model
`default_nettype wire

//--- tb/ecl_loader_tb.sv
// self-checking bench for the reset configuration loader
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_tb;
  import ecl_pkg::*;
  logic clk, rst_n, rd, wr, present, ee_cs, ee_sk, ee_di, ee_do, load_done, wait_req;
  logic [6:0] addr;
  logic [31:0] wdata, rdat, rdata;
  logic [3:0] be;
  logic [15:0] io_base, io_v, v;
  logic [15:0] rom [4];
  logic [47:0] node;
  int miscompares, n_checks, cyc, n;
  ecl_loader ecl_loader_i (.clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .io_base_out(io_base), .load_done_out(load_done),
    .ee_cs_out(ee_cs), .ee_sk_out(ee_sk), .ee_di_out(ee_di), .ee_do_in(ee_do));
  ecl_ee_model ecl_ee_model_i (.present_in(present), .cs_in(ee_cs), .sk_in(ee_sk), .di_in(ee_di),
    .do_out(ee_do));
  // ******************************
  // clock, watchdog, reporting
  // ******************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ceiling covers three reset loads, one reload and eight software reads with wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ******************************
  // bus and sequencing tasks
  // ******************************
  // request held until the edge that sees waitrequest low, then one idle edge
  task av_xfer(input logic w, input logic [6:0] a, input logic [31:0] wd, input logic [3:0] b);
    int k;
    k = 0;
    addr <= a;
    wdata <= wd;
    be <= b;
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wait_req !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    rdat = rdata;
    if (k >= 50) begin
      chk(32'h1, 32'h0);
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : av_xfer
  task do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 12000), 32'h1);
  endtask : do_reset
  // reset block: header, io base group, four words at 030h, checksum word
  task set_block(input logic bad);
    logic [15:0] b [9];
    logic [7:0] s;
    b[0] = {EE_TYPE_NIB, 12'h110};
    b[1] = 16'h0020;
    b[2] = io_v;
    b[3] = 16'h3030;
    for (int i = 0; i < 4; i++) begin
      b[4 + i] = rom[i];
    end
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + b[i][15:8] + b[i][7:0];
    end
    b[8] = {(8'h00 - s) ^ {7'h00, bad}, 8'h00};
    for (int i = 0; i < 9; i++) begin
      ecl_ee_model_i.mem[i] = b[i];
    end
  endtask : set_block
  // ******************************
  // tests
  // ******************************
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 7'h00;
    wdata = 32'h0;
    be = 4'h0;
    present = 1'b0;
    cyc = 0;
    void'($urandom(32'he0fdff14));
    // absent part: pulled-up line reads as no eeprom
    do_reset();
    chk({16'h0, io_base}, 32'h0300);
    av_xfer(0, REG_STAT, 32'h0, 4'hf);
    chk(rdat & 32'h0e, 32'h04);
    av_xfer(0, REG_EEADDR, 32'h0, 4'hf);
    chk(rdat, {24'h0, EE_DRV_ADDR});
    $display("test absent done");
    // present part with random io base and boot rom words
    io_v = 16'($urandom());
    for (int i = 0; i < 4; i++) begin
      rom[i] = 16'($urandom());
    end
    set_block(1'b0);
    present <= 1'b1;
    do_reset();
    chk(32'(n >= 9 * WORD_CYC * 9 / 10 && n <= 9 * WORD_CYC * 11 / 10), 32'h1);
    chk({16'h0, io_base}, {16'h0, io_v});
    av_xfer(0, REG_WIN + 7'h20, 32'h0, 4'hf);
    chk(rdat, {16'h0, io_v});
    for (int i = 0; i < 4; i++) begin
      av_xfer(0, REG_WIN + 7'h30 + 7'(i), 32'h0, 4'hf);
      chk(rdat, {16'h0, rom[i]});
    end
    av_xfer(0, REG_STAT, 32'h0, 4'hf);
    chk(rdat & 32'h0e, 32'h06);
    $display("test load done");
    // corrupt checksum: flagged, data still applied
    io_v = io_v ^ 16'h0101;
    set_block(1'b1);
    do_reset();
    av_xfer(0, REG_STAT, 32'h0, 4'hf);
    chk(rdat & 32'h0e, 32'h0e);
    chk({16'h0, io_base}, {16'h0, io_v});
    $display("test checksum done");
    // software word reads of the driver block and the top address
    node = {16'($urandom()), 32'($urandom())};
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom());
      case (i)
        0, 1, 2: v = {node[39 - 16 * i -: 8], node[47 - 16 * i -: 8]};
        3: v = {v[15:7], 1'b0, v[5:4], 2'h0, v[1:0]};
        4, 5, 6: v = {v[15:4], 4'h0};
        default: v = v;
      endcase
      ecl_ee_model_i.mem[(i < 7) ? 8'h1c + 8'(i) : 8'hff] = v;
      av_xfer(1, REG_EEADDR, (i < 7) ? 32'h1c + 32'(i) : 32'hff, 4'hf);
      av_xfer(1, REG_CTRL, 32'h1, 4'hf);
      rdat = 32'h0;
      // a word takes over 600 cycles and each poll three, so allow well above that
      for (int k = 0; k < 400 && rdat[STAT_RDDONE] !== 1'b1; k++) begin
        av_xfer(0, REG_STAT, 32'h0, 4'hf);
      end
      chk(32'(rdat[STAT_RDDONE]), 32'h1);
      av_xfer(0, REG_EEDATA, 32'h0, 4'hf);
      chk(rdat, {16'h0, v});
    end
    $display("test software read done");
    // window write, narrow write refused, unmapped index
    v = 16'($urandom());
    av_xfer(1, REG_WIN + 7'h05, {16'h0, v}, 4'h3);
    av_xfer(1, REG_WIN + 7'h05, {16'h0, ~v}, 4'h1);
    av_xfer(0, REG_WIN + 7'h05, 32'h0, 4'hf);
    chk(rdat, {16'h0, v});
    av_xfer(0, 7'h3f, 32'h0, 4'hf);
    chk(rdat, 32'h0);
    $display("test registers done");
    // software reload of the reset block with a fresh io base
    io_v = 16'($urandom());
    set_block(1'b0);
    av_xfer(1, REG_CTRL, 32'h2, 4'hf);
    n = 0;
    while (load_done !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(32'(load_done), 32'h0);
    n = 0;
    while (load_done !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 9 * WORD_CYC * 9 / 10 && n <= 9 * WORD_CYC * 11 / 10), 32'h1);
    chk({16'h0, io_base}, {16'h0, io_v});
    av_xfer(0, REG_STAT, 32'h0, 4'hf);
    chk(rdat & 32'h0e, 32'h06);
    $display("test reload done");
    results();
  end
endmodule : ecl_loader_tb
`default_nettype wire
